// ---- rtl/dcs_debug_control_status.v ----
`include "dcs_defs.vh"
`default_nettype none
module dcs_debug_control_status (
   input  wire       i_core_clk,
   input  wire       i_sys_rst,
   input  wire       i_cmd_valid,
   input  wire [7:0] i_cmd_byte,
   input  wire       i_brk_decoded,
   input  wire       i_reset_done,
   input  wire       i_cpu_lowpwr,
   input  wire       i_lock_option_n,
   output reg        o_rsp_valid,
   output reg  [7:0] o_rsp_byte,
   output reg        o_cpu_fetch_stop,
   output reg        o_brk_as_nop,
   output reg        o_brk_spin,
   output reg        o_dev_reset,
   output reg  [7:0] o_debug_control_reg,
   output reg  [7:0] o_debug_status_reg
);
   // command decoder states, one-hot
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_DATA = 3'b010;
   localparam [2:0] ST_SEND = 3'b100;

   reg [2:0] state_q;
   reg [2:0] state_d;
   reg       halt_q;
   reg       breakpoint_enable_bit_q;
   reg       ack_q;
   reg       spin_q;
   reg       srst_q;
   reg       brk_hist_q;
   reg [7:0] send_q;
   reg [7:0] send_d;
   reg       send_pend_q;
   reg       ack_pend_q;
   // next values, worked out combinationally
   reg       halt_d;
   reg       breakpoint_enable_bit_d;
   reg       ack_d;
   reg       spin_d;
   reg       srst_d;
   reg       brk_hist_d;
   reg       send_pend_d;
   reg       ack_pend_d;
   reg       rsp_valid_d;
   reg [7:0] rsp_byte_d;
   reg       fetch_stop_d;
   reg       brk_nop_d;
   reg       brk_spin_d;
   reg       dev_reset_d;
   reg [7:0] ctl_reg_d;
   reg [7:0] sta_reg_d;

   wire       lowpwr_s;
   wire       lock_n_s;
   wire       read_lock_active;
   wire       ctl_wr;
   wire [7:0] wdata;
   wire       brk_taken;
   wire       brk_halts;
   wire [7:0] ctl_value;
   wire [7:0] sta_value;
   wire       srst_finish;

   // the low-power and lock-option pins are double-flopped; command inputs are used as they come
   dcs_sync2 #(
      .W (2)
   ) u_sync (
      .i_core_clk (i_core_clk),
      .i_sys_rst  (i_sys_rst),
      .i_async    ({i_cpu_lowpwr, i_lock_option_n}),
      .o_sync     ({lowpwr_s, lock_n_s})
   );

   // option bit is active when programmed to 0
   assign read_lock_active = ~lock_n_s;
   assign wdata     = i_cmd_byte;
   assign srst_finish = srst_q && i_reset_done;
   assign ctl_wr    = (state_q == ST_DATA) && i_cmd_valid;
   assign brk_taken = i_brk_decoded && breakpoint_enable_bit_q;
   assign brk_halts = brk_taken && !spin_q;
   // bits 3..1 always read back as zero whatever the host wrote
   assign ctl_value = {halt_q, breakpoint_enable_bit_q, ack_q, spin_q, 3'b000, srst_q};
   assign sta_value = {(halt_q | brk_hist_q), lowpwr_s, read_lock_active,
                       `DCS_STA_RESERVED};

   always @* begin
      state_d = state_q;
      send_d  = send_q;
      case (state_q)
         ST_IDLE: begin
            if (i_cmd_valid) begin
               if (i_cmd_byte == `DCS_CMD_WR_CTRL) begin
                  state_d = ST_DATA;
               end else if (i_cmd_byte == `DCS_CMD_RD_CTRL) begin
                  state_d = ST_SEND;
                  send_d  = ctl_value;
               end else if (i_cmd_byte == `DCS_CMD_RD_STATUS) begin
                  state_d = ST_SEND;
                  send_d  = sta_value;
               end
            end
         end
         ST_DATA: begin
            if (i_cmd_valid) begin
               state_d = ST_IDLE;
            end
         end
         ST_SEND: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state_q <= ST_IDLE;
         send_q  <= 8'h00;
      end else begin
         state_q <= state_d;
         send_q  <= send_d;
      end
   end

   // control register: i_sys_rst is the debugger's own reset, never the self reset
   // halt flag: hardware set wins over a software clear in the same cycle
   always @* begin
      halt_d = halt_q;
      if (brk_halts) begin
         halt_d = 1'b1;
      end else if (ctl_wr) begin
         if (wdata[`DCS_CTL_HALT]) begin
            halt_d = 1'b1;
         end else if (!read_lock_active) begin
            halt_d = 1'b0;
         end
      end else if (srst_finish && read_lock_active) begin
         // under read lock only a device reset lets the cpu out
         halt_d = 1'b0;
      end
   end

   // mode bits follow the host's data byte and nothing else
   always @* begin
      breakpoint_enable_bit_d = breakpoint_enable_bit_q;
      ack_d   = ack_q;
      spin_d  = spin_q;
      if (ctl_wr) begin
         breakpoint_enable_bit_d = wdata[`DCS_CTL_BREAKPOINT_ENABLE_BIT];
         ack_d   = wdata[`DCS_CTL_ACK];
         spin_d  = wdata[`DCS_CTL_SPIN];
      end
   end

   // writing 0 never clears a reset in progress
   always @* begin
      srst_d = srst_q;
      if (ctl_wr && wdata[`DCS_CTL_SRST]) begin
         srst_d = 1'b1;
      end else if (srst_finish) begin
         srst_d = 1'b0;
      end
   end

   // breakpoint history since the last control write; a new breakpoint wins
   always @* begin
      brk_hist_d = brk_hist_q;
      if (brk_taken) begin
         brk_hist_d = 1'b1;
      end else if (ctl_wr) begin
         brk_hist_d = 1'b0;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         halt_q <= 1'b0;
      end else begin
         halt_q <= halt_d;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         breakpoint_enable_bit_q <= 1'b0;
      end else begin
         breakpoint_enable_bit_q <= breakpoint_enable_bit_d;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         spin_q <= 1'b0;
      end else begin
         spin_q <= spin_d;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= srst_d;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         brk_hist_q <= 1'b0;
      end else begin
         brk_hist_q <= brk_hist_d;
      end
   end

   // response byte: a pending command reply takes priority, ack waits one slot
   // a second ack inside the waiting slot merges with the first one
   always @* begin
      send_pend_d = (state_q == ST_SEND);
      ack_pend_d  = ack_pend_q;
      rsp_valid_d = 1'b0;
      rsp_byte_d  = o_rsp_byte;
      if (send_pend_q) begin
         rsp_valid_d = 1'b1;
         rsp_byte_d  = send_q;
         if (brk_taken && ack_q) begin
            ack_pend_d = 1'b1;
         end
      end else if (ack_pend_q || (brk_taken && ack_q)) begin
         rsp_valid_d = 1'b1;
         rsp_byte_d  = `DCS_ACK_BYTE;
         ack_pend_d  = 1'b0;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         send_pend_q <= 1'b0;
         ack_pend_q  <= 1'b0;
         o_rsp_valid <= 1'b0;
         o_rsp_byte  <= 8'h00;
      end else begin
         send_pend_q <= send_pend_d;
         ack_pend_q  <= ack_pend_d;
         o_rsp_valid <= rsp_valid_d;
         o_rsp_byte  <= rsp_byte_d;
      end
   end

   // pin-facing copies, each straight from a flip-flop
   always @* begin
      fetch_stop_d = halt_q;
      brk_nop_d    = ~breakpoint_enable_bit_q;
      brk_spin_d   = breakpoint_enable_bit_q & spin_q;
      dev_reset_d  = srst_q;
      ctl_reg_d    = ctl_value;
      sta_reg_d    = sta_value;
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_cpu_fetch_stop <= 1'b0;
      end else begin
         o_cpu_fetch_stop <= fetch_stop_d;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_brk_as_nop <= 1'b1;
      end else begin
         o_brk_as_nop <= brk_nop_d;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_brk_spin <= 1'b0;
      end else begin
         o_brk_spin <= brk_spin_d;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_dev_reset <= 1'b0;
      end else begin
         o_dev_reset <= dev_reset_d;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_debug_control_reg <= `DCS_CTL_RESET;
      end else begin
         o_debug_control_reg <= ctl_reg_d;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_debug_status_reg <= 8'h00;
      end else begin
         o_debug_status_reg <= sta_reg_d;
      end
   end
endmodule
`default_nettype wire

// ---- rtl/dcs_defs.vh ----
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH
// host command codes
`define DCS_CMD_RD_STATUS  8'h02
`define DCS_CMD_WR_CTRL    8'h04
`define DCS_CMD_RD_CTRL    8'h05
// control field positions
`define DCS_CTL_HALT       7
`define DCS_CTL_BREAKPOINT_ENABLE_BIT      6
`define DCS_CTL_ACK        5
`define DCS_CTL_SPIN       4
`define DCS_CTL_SRST       0
// status field positions
`define DCS_STA_IDLE       7
`define DCS_STA_LOWPWR     6
`define DCS_STA_RLOCK      5
// reset values and constants
`define DCS_CTL_RESET      8'h00
`define DCS_STA_RESERVED   5'h00
`define DCS_ACK_BYTE       8'hff
`define DCS_BRK_OPCODE     8'h00
`endif

// ---- rtl/dcs_sync2.v ----
`default_nettype none
module dcs_sync2 #(
   parameter W = 1
) (
   input  wire         i_core_clk,
   input  wire         i_sys_rst,
   input  wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;
   always @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end
   assign o_sync = sync_q;
endmodule
`default_nettype wire

// ---- sim/dcs_properties.sv ----
`default_nettype none
module dcs_properties (
   input wire logic       i_core_clk,
   input wire logic       i_sys_rst,
   input wire logic       i_cmd_valid,
   input wire logic       i_brk_decoded,
   input wire logic       i_reset_done,
   input wire logic       i_cpu_lowpwr,
   input wire logic       i_lock_option_n,
   input wire logic       o_rsp_valid,
   input wire logic [7:0] o_rsp_byte,
   input wire logic       o_cpu_fetch_stop,
   input wire logic       o_brk_as_nop,
   input wire logic       o_dev_reset,
   input wire logic [7:0] o_debug_control_reg,
   input wire logic [7:0] o_debug_status_reg
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   wire logic [7:0] c = o_debug_control_reg;
   wire logic [7:0] s = o_debug_status_reg;
   sta_rsv_zero_a: assert property (s[4:0] == 5'h00) else $error("status low bits set");
   ctl_rsv_zero_a: assert property (c[3:1] == 3'h0) else $error("control bits 3..1 set");
   brk_halts_a: assert property (i_brk_decoded && c[6] && !c[4] && $stable(c) |-> ##[1:3] o_cpu_fetch_stop)
      else $error("no halt on breakpoint");
   brk_spin_a: assert property (i_brk_decoded && c[6] && c[4] && !o_cpu_fetch_stop && !i_cmd_valid
      |-> ##2 !o_cpu_fetch_stop) else $error("spin set halt");
   brk_nop_a: assert property (i_brk_decoded && o_brk_as_nop && !o_cpu_fetch_stop && !i_cmd_valid
      |-> ##2 !o_cpu_fetch_stop) else $error("disabled breakpoint halted");
   ack_byte_a: assert property (i_brk_decoded && c[6] && c[5] && $stable(c)
      |-> ##[1:3] (o_rsp_valid && o_rsp_byte == 8'hff)) else $error("no ack byte");
   halt_idle_a: assert property (o_cpu_fetch_stop |-> ##[0:1] s[7]) else $error("idle bit low");
   lowpwr_flag_a: assert property (i_cpu_lowpwr[*4] |-> s[6]) else $error("low power bit low");
   rlock_flag_a: assert property ((!i_lock_option_n)[*4] |-> s[5]) else $error("lock bit low");
   dev_rst_hold_a: assert property (o_dev_reset && !i_reset_done && !$past(i_reset_done) |=> o_dev_reset)
      else $error("reset dropped");
   dev_rst_end_a: assert property (o_dev_reset && i_reset_done |-> ##[1:2] !o_dev_reset) else $error("reset stuck");
endmodule
bind dcs_debug_control_status dcs_properties u_chk (.i_core_clk, .i_sys_rst, .i_cmd_valid, .i_brk_decoded,
   .i_reset_done, .i_cpu_lowpwr, .i_lock_option_n, .o_rsp_valid, .o_rsp_byte, .o_cpu_fetch_stop, .o_brk_as_nop,
   .o_dev_reset, .o_debug_control_reg, .o_debug_status_reg);
`default_nettype wire

// ---- sim/dcs_host_model.sv ----
`default_nettype none
module dcs_host_model (
   input  wire logic       i_core_clk,
   output var  logic       o_cmd_valid,
   output var  logic [7:0] o_cmd_byte
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_cmd_valid = 1'b0;
      o_cmd_byte  = 8'h5a;
   end
   // released byte lane flips so a stale value never looks valid
   task automatic send(input logic [7:0] b);
      @(negedge i_core_clk);
      o_cmd_valid = 1'b1;
      o_cmd_byte  = b;
      @(negedge i_core_clk);
      o_cmd_valid = 1'b0;
      o_cmd_byte  = ~b;
   endtask
   task automatic wr_ctrl(input logic [7:0] d);
      send(8'h04);
      send({d[7:4], 3'h0, d[0]});
   endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk, rst, breakpoint_opcode, done, lp, lock_n, cv, rv, stop, nop, spin, dr;
   logic [7:0] cb, rb, ctl, sta;
   int         miscompares = 0, n_tests = 0;
   dcs_debug_control_status dut (.i_core_clk(clk), .i_sys_rst(rst), .i_cmd_valid(cv), .i_cmd_byte(cb),
      .i_brk_decoded(breakpoint_opcode), .i_reset_done(done), .i_cpu_lowpwr(lp), .i_lock_option_n(lock_n), .o_rsp_valid(rv),
      .o_rsp_byte(rb), .o_cpu_fetch_stop(stop), .o_brk_as_nop(nop), .o_brk_spin(spin), .o_dev_reset(dr),
      .o_debug_control_reg(ctl), .o_debug_status_reg(sta));
   dcs_host_model host (.i_core_clk(clk), .o_cmd_valid(cv), .o_cmd_byte(cb));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [7:0] cmd, input logic [7:0] e);
      int i;
      host.send(cmd);
      for (i = 0; i < 4 && rv !== 1'b1; i++) @(posedge clk) #1;
      chk("reply", rv === 1'b1 ? rb : ~e, e);
   endtask
   task automatic pulse_brk;
      @(negedge clk);
      breakpoint_opcode = 1'b1;
      @(negedge clk);
      breakpoint_opcode = 1'b0;
      repeat (3) @(negedge clk);
   endtask
   task automatic sr(input logic [7:0] d, input logic [7:0] e);
      host.wr_ctrl(d);
      repeat (3) @(negedge clk);
      chk("dev reset", {7'h0, dr}, 8'h01);
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      repeat (3) @(negedge clk);
      chk("dev reset", {7'h0, dr}, 8'h00);
      rd(8'h05, e);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      logic [31:0] r;
      {rst, breakpoint_opcode, done, lp, lock_n} = 5'h11;
      r = $urandom(32'hda75);
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      rd(8'h02, 8'h00);
      rd(8'h05, 8'h00);
      repeat (8) begin
         r = $urandom;
         lp = r[8];
         done = r[9];
         host.wr_ctrl(r[7:0] & 8'hf0);
         rd(8'h05, r[7:0] & 8'hf0);
         rd(8'h02, {r[7], lp, 6'h00});
         chk("fetch stop", {7'h0, stop}, {7'h0, r[7]});
         chk("nop", {7'h0, nop}, {7'h0, ~r[6]});
         chk("spin", {7'h0, spin}, {7'h0, r[6] & r[4]});
         chk("ctl reg", ctl, r[7:0] & 8'hf0);
         chk("status reg", sta, {r[7], lp, 6'h00});
      end
      lp = 1'b0;
      done = 1'b0;
      host.wr_ctrl(8'h60);
      pulse_brk;
      chk("ack", rb, 8'hff);
      rd(8'h02, 8'h80);
      host.wr_ctrl(8'h40);
      rd(8'h02, 8'h00);
      host.wr_ctrl(8'h50);
      pulse_brk;
      rd(8'h02, 8'h80);
      host.wr_ctrl(8'h00);
      pulse_brk;
      rd(8'h02, 8'h00);
      lock_n = 1'b0;
      host.wr_ctrl(8'h80);
      host.wr_ctrl(8'h00);
      rd(8'h02, 8'ha0);
      sr(8'h41, 8'h40);
      lock_n = 1'b1;
      sr(8'h81, 8'h80);
      chk("fetch stop", {7'h0, stop}, 8'h01);
      sr(8'h41, 8'h40);
      chk("fetch stop", {7'h0, stop}, 8'h00);
      final_report;
   end
   // the sequence needs well under a thousand cycles
   initial begin
      #2ms;
      miscompares++;
      final_report;
   end
endmodule
`default_nettype wire
